// >>> logic/fqcs_device.v
// Device end of the flash query command sequencer
// Contract
// - All addressed blocks blank gives status 06H, read as normal by host.
// - Block count outside permitted range gives parameter error 05H.
// - Checksum mismatch in an otherwise well-formed command frame gives status 07H.
// - Malformed frame, bad length or missing end-of-text, gives 15H.
// - Any addressed block found not blank gives margin error 1BH.
// - Failing protection read gives read error 20H for signature.
`timescale 1ns/1ps
`include "fqcs_defines.vh"
module fqcs_device
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Received frame bytes
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    // Transmitted frame bytes
    output reg o_tx_valid,
    output reg [7:0] o_tx_byte,
    input wire i_tx_ready,
    // Flash check interface
    output reg o_chk_req,
    output reg [7:0] o_chk_block,
    input wire i_chk_done,
    input wire i_chk_blank,
    input wire i_prot_fail,
    // Status
    output reg o_busy
);
    localparam S_SOH = 4'h0;
    localparam S_LEN = 4'h1;
    localparam S_BODY = 4'h2;
    localparam S_SUM = 4'h3;
    localparam S_ETX = 4'h4;
    localparam S_EXEC = 4'h5;
    localparam S_CHECK = 4'h6;
    localparam S_TX = 4'h7;

    reg [3:0] state_reg;
    reg [7:0] len_reg;
    reg [7:0] cnt_reg;
    reg [7:0] cmd_reg;
    reg [7:0] nblk_reg;
    reg [7:0] status_reg;
    reg [7:0] blk_reg;
    // Room for a status frame and the longest data frame behind it
    reg [7:0] txbuf_reg [0:12];
    reg [3:0] txlen_reg;
    reg [3:0] txidx_reg;
    reg bad_len_reg;
    wire rx_clear;
    wire [7:0] rx_sum;
    wire tx_take;
    integer k;

    assign rx_clear = (state_reg == S_SOH);
    assign tx_take = o_tx_valid && i_tx_ready;

    fqcs_csum u_rx_sum
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(rx_clear),
        .i_valid(i_rx_valid && (state_reg == S_LEN || state_reg == S_BODY)),
        .i_byte(i_rx_byte),
        .o_sum(rx_sum)
    );

    // --------------------------------------------------
    // Reply frame builder
    // --------------------------------------------------
    // Status frame: 02 LEN ST1 SUM ETX; data frames add payload after status
    task build_reply;
        input [7:0] st;
        input [7:0] plen;
        input [31:0] pay;
        reg [7:0] s;
        integer j;
        begin
            s = 8'h00 - 8'h01 - st;
            txbuf_reg[0] <= 8'h02;
            txbuf_reg[1] <= 8'h01;
            txbuf_reg[2] <= st;
            txbuf_reg[3] <= s;
            txbuf_reg[4] <= `FQCS_ETX;
            s = 8'h00 - plen;
            txbuf_reg[5] <= 8'h02;
            txbuf_reg[6] <= plen;
            for (j = 0; j < 4; j = j + 1)
            begin
                txbuf_reg[7 + j] <= pay[31 - 8 * j -: 8];
                if (j < plen)
                    s = s - pay[31 - 8 * j -: 8];
            end
            txbuf_reg[7 + plen] <= s;
            txbuf_reg[8 + plen] <= `FQCS_ETX;
            txlen_reg <= (st == `FQCS_ST_ACK && plen != 8'h00) ? 4'd9 + plen[3:0] : 4'd5;
        end
    endtask

    // --------------------------------------------------
    // Command interpreter
    // --------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= S_SOH;
            len_reg <= 8'h00;
            cnt_reg <= 8'h00;
            cmd_reg <= 8'h00;
            nblk_reg <= 8'h00;
            status_reg <= 8'h00;
            blk_reg <= 8'h00;
            txlen_reg <= 4'd0;
            txidx_reg <= 4'd0;
            bad_len_reg <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_byte <= 8'h00;
            o_chk_req <= 1'b0;
            o_chk_block <= 8'h00;
            o_busy <= 1'b0;
            for (k = 0; k < 13; k = k + 1)
                txbuf_reg[k] <= 8'h00;
        end
        else
        begin
            case (state_reg)
                S_SOH:
                begin
                    o_busy <= 1'b0;
                    if (i_rx_valid && i_rx_byte == `FQCS_SOH)
                    begin
                        state_reg <= S_LEN;
                        o_busy <= 1'b1;
                    end
                end
                S_LEN:
                    if (i_rx_valid)
                    begin
                        len_reg <= i_rx_byte;
                        cnt_reg <= 8'h00;
                        nblk_reg <= 8'h00;
                        // Zero or oversize length cannot be parsed; count it malformed
                        bad_len_reg <= (i_rx_byte == 8'h00) || (i_rx_byte > `FQCS_MAX_LEN);
                        state_reg <= (i_rx_byte == 8'h00 || i_rx_byte > `FQCS_MAX_LEN) ? S_SUM : S_BODY;
                    end
                S_BODY:
                    if (i_rx_valid)
                    begin
                        if (cnt_reg == 8'h00)
                            cmd_reg <= i_rx_byte;
                        // Last parameter byte carries the block count
                        nblk_reg <= i_rx_byte;
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg + 8'h01 == len_reg)
                            state_reg <= S_SUM;
                    end
                S_SUM:
                    if (i_rx_valid)
                    begin
                        status_reg <= (rx_sum != i_rx_byte) ? `FQCS_ST_CSUM_ERR : `FQCS_ST_ACK;
                        state_reg <= S_ETX;
                    end
                S_ETX:
                    if (i_rx_valid)
                    begin
                        if (i_rx_byte != `FQCS_ETX || bad_len_reg)
                            status_reg <= `FQCS_ST_NACK;
                        state_reg <= S_EXEC;
                    end
                S_EXEC:
                begin
                    state_reg <= S_TX;
                    txidx_reg <= 4'd0;
                    if (status_reg != `FQCS_ST_ACK)
                        build_reply(status_reg, 8'h00, 32'h0);
                    else if (cmd_reg == `FQCS_CMD_BLANK && len_reg == 8'h01)
                        build_reply(`FQCS_ST_NACK, 8'h00, 32'h0);
                    else if (cmd_reg == `FQCS_CMD_BLANK)
                    begin
                        if (nblk_reg == 8'h00 || nblk_reg > `FQCS_MAX_BLOCKS)
                            build_reply(`FQCS_ST_PARAM_ERR, 8'h00, 32'h0);
                        else
                        begin
                            // Blocks checked one at a time, stop at the first dirty one
                            blk_reg <= 8'h00;
                            o_chk_block <= 8'h00;
                            o_chk_req <= 1'b1;
                            state_reg <= S_CHECK;
                        end
                    end
                    else if (cmd_reg == `FQCS_CMD_SIG)
                    begin
                        if (i_prot_fail)
                            build_reply(`FQCS_ST_READ_ERR, 8'h00, 32'h0);
                        else
                            build_reply(`FQCS_ST_ACK, `FQCS_SIG_LEN, `FQCS_SIG_WORD);
                    end
                    else if (cmd_reg == `FQCS_CMD_VER)
                        build_reply(`FQCS_ST_ACK, `FQCS_VER_LEN, {`FQCS_VER_WORD, 8'h00});
                    else
                        build_reply(`FQCS_ST_NACK, 8'h00, 32'h0);
                end
                S_CHECK:
                    if (i_chk_done)
                    begin
                        if (!i_chk_blank)
                        begin
                            o_chk_req <= 1'b0;
                            build_reply(`FQCS_ST_MARGIN_ERR, 8'h00, 32'h0);
                            state_reg <= S_TX;
                        end
                        else if (blk_reg + 8'h01 == nblk_reg)
                        begin
                            o_chk_req <= 1'b0;
                            // Status only, no data frame after blank check
                            build_reply(`FQCS_ST_ACK, 8'h00, 32'h0);
                            state_reg <= S_TX;
                        end
                        else
                        begin
                            blk_reg <= blk_reg + 8'h01;
                            o_chk_block <= blk_reg + 8'h01;
                        end
                    end
                S_TX:
                begin
                    o_tx_valid <= 1'b1;
                    o_tx_byte <= txbuf_reg[txidx_reg];
                    if (tx_take)
                    begin
                        if (txidx_reg + 4'd1 == txlen_reg)
                        begin
                            o_tx_valid <= 1'b0;
                            // Busy drops with the last byte taken
                            o_busy <= 1'b0;
                            state_reg <= S_SOH;
                        end
                        else
                        begin
                            txidx_reg <= txidx_reg + 4'd1;
                            o_tx_byte <= txbuf_reg[txidx_reg + 4'd1];
                        end
                    end
                end
                default:
                    state_reg <= S_SOH;
            endcase
        end
    end
endmodule

// >>> shared/fqcs_defines.vh
// Constants for the flash query command sequencer (device side)
`ifndef FQCS_DEFINES_VH
`define FQCS_DEFINES_VH

// Status codes
`define FQCS_ST_ACK 8'h06
`define FQCS_ST_PARAM_ERR 8'h05
`define FQCS_ST_CSUM_ERR 8'h07
`define FQCS_ST_NACK 8'h15
`define FQCS_ST_MARGIN_ERR 8'h1B
`define FQCS_ST_READ_ERR 8'h20

// Command codes
`define FQCS_CMD_BLANK 8'h32
`define FQCS_CMD_SIG 8'hC0
`define FQCS_CMD_VER 8'hC5

// Frame layout
`define FQCS_SOH 8'h01
`define FQCS_ETX 8'h03
`define FQCS_MAX_LEN 8'h08
`define FQCS_MAX_BLOCKS 8'h80
`define FQCS_SIG_LEN 8'h04
`define FQCS_VER_LEN 8'h03

// Signature and version payload, arbitrary values
`define FQCS_SIG_WORD 32'h10203040
`define FQCS_VER_WORD 24'h010203

`endif

// >>> logic/fqcs_csum.v
// Running two's complement checksum over a byte stream
`timescale 1ns/1ps
module fqcs_csum
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Stream
    input wire i_clear,
    input wire i_valid,
    input wire [7:0] i_byte,
    // Result
    output wire [7:0] o_sum
);
    reg [7:0] acc_reg;

    // Checksum makes the total of all bytes zero
    always @(posedge i_clk)
    begin
        if (i_rst || i_clear)
            acc_reg <= 8'h00;
        else if (i_valid)
            acc_reg <= acc_reg - i_byte;
    end

    assign o_sum = acc_reg;
endmodule

// >>> tb/fqcs_device_sva.sv
// Port checker for the device sequencer
`timescale 1ns/1ps
module fqcs_device_sva
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Frames
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire o_tx_valid,
    input wire [7:0] o_tx_byte,
    input wire i_tx_ready,
    // Flash check and status
    input wire o_chk_req,
    input wire [7:0] o_chk_block,
    input wire i_chk_done,
    input wire i_chk_blank,
    input wire i_prot_fail,
    input wire o_busy
);
// ----------
// Properties
// ----------
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
a_tx_byte_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("reply byte dropped before taken");
a_tx_when_busy: assert property (o_tx_valid |-> o_busy)
    else $error("reply offered while idle");
a_scan_quiet: assert property (o_chk_req |-> o_busy && !o_tx_valid)
    else $error("scan overlaps reply");
a_block_held: assert property (o_chk_req && !i_chk_done |=> !o_chk_req || $stable(o_chk_block))
    else $error("block index moved before result");
a_frame_start: assert property ($rose(o_tx_valid) |-> o_tx_byte == 8'h02)
    else $error("reply frame does not open with 02");
a_soh_busy: assert property (!o_busy && i_rx_valid && i_rx_byte == 8'h01 |=> o_busy)
    else $error("frame start not taken");
a_scan_reply: assert property ($fell(o_chk_req) |-> ##[0:4] o_tx_valid)
    else $error("no status after scan");
a_busy_ends: assert property ($fell(o_busy) |-> $past(o_tx_valid && i_tx_ready))
    else $error("busy dropped without last byte");
c_dirty: cover property (o_chk_req && i_chk_done && !i_chk_blank);
c_stall: cover property (o_tx_valid && !i_tx_ready);
c_done: cover property ($fell(o_busy));
endmodule
bind fqcs_device fqcs_device_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
    .i_rx_byte(i_rx_byte), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready),
    .o_chk_req(o_chk_req), .o_chk_block(o_chk_block), .i_chk_done(i_chk_done),
    .i_chk_blank(i_chk_blank), .i_prot_fail(i_prot_fail), .o_busy(o_busy));

// >>> tb/fqcs_host_model.sv
// Reply sink and flash array model for the device sequencer
`timescale 1ns/1ps
module fqcs_host_model
(
    // Clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic [7:0] i_dirty,
    // Reply bytes
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    output logic o_tx_ready,
    // Flash check
    input wire logic i_chk_req,
    input wire logic [7:0] i_chk_block,
    output logic o_chk_done,
    output logic o_chk_blank
);
// ------
// Model
// ------
logic [7:0] got[$];
logic [1:0] cnt_reg;
always @(posedge i_clk)
begin
    if (i_tx_valid && o_tx_ready)
        got.push_back(i_tx_byte);
    o_tx_ready <= i_rst ? 1'b0 : (i_slow ? ~o_tx_ready : 1'b1);
    cnt_reg <= (i_rst || !i_chk_req) ? 2'h0 : cnt_reg + 2'h1;
end
// Result every fourth cycle, so a late index update is never answered twice
assign o_chk_done = (cnt_reg == 2'h3);
// Result line toggles outside done; only the named block is not blank
assign o_chk_blank = o_chk_done ? (i_chk_block != i_dirty) : cnt_reg[0];
endmodule

// >>> tb/fqcs_device_bench.sv
// Self-checking bench for the device sequencer
`timescale 1ns/1ps
`include "fqcs_defines.vh"
module fqcs_device_bench;
// -------
// Harness
// -------
logic i_clk = 1'b0;
logic i_rst = 1'b1;
logic i_rx_valid = 1'b0;
logic i_prot_fail = 1'b0;
logic slow = 1'b0;
logic [7:0] i_rx_byte = 8'h00;
logic [7:0] dirty = 8'hFF;
wire o_tx_valid, i_tx_ready, o_chk_req, i_chk_done, i_chk_blank, o_busy;
wire [7:0] o_tx_byte, o_chk_block;
integer miscompares = 0;
integer comparisons = 0;
integer cycles = 0;
localparam int blank_check_timeout_per_block = 8;
logic [7:0] exp_q[$];
fqcs_device u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte),
    .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .o_chk_req(o_chk_req),
    .o_chk_block(o_chk_block), .i_chk_done(i_chk_done), .i_chk_blank(i_chk_blank),
    .i_prot_fail(i_prot_fail), .o_busy(o_busy));
fqcs_host_model u_host (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_dirty(dirty),
    .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .o_tx_ready(i_tx_ready), .i_chk_req(o_chk_req),
    .i_chk_block(o_chk_block), .o_chk_done(i_chk_done), .o_chk_blank(i_chk_blank));
initial
    forever #25 i_clk = ~i_clk;
always @(posedge i_clk)
begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
        miscompares = miscompares + 1;
        summarize;
    end
end
task summarize;
begin
    if (miscompares == 0 && comparisons > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
task check(input [7:0] seen, input [7:0] exp);
begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
end
endtask
task put(input [7:0] b);
begin
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    i_rx_byte <= b;
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
end
endtask
// Sends one command frame and judges the whole reply
task run(input [7:0] c, input [7:0] n, input [7:0] len, input [7:0] fix, input [7:0] etx, input [7:0] st);
    integer i;
    logic [7:0] s;
    logic [7:0] plen;
    logic [31:0] pay;
    integer limit;
    logic [7:0] outcome;
begin
    s = 8'h00 - len - c - ((len == 8'h02) ? n : 8'h00) + fix;
    exp_q = '{8'h02, 8'h01, st, 8'h00 - 8'h01 - st, 8'h03};
    pay = (c == `FQCS_CMD_SIG) ? `FQCS_SIG_WORD : {`FQCS_VER_WORD, 8'h00};
    plen = (c == `FQCS_CMD_SIG) ? 8'h04 : 8'h03;
    if (st == 8'h06 && c != `FQCS_CMD_BLANK)
    begin
        exp_q.push_back(8'h02);
        exp_q.push_back(plen);
        s = 8'h00 - plen;
        for (i = 0; i < plen; i = i + 1)
        begin
            exp_q.push_back(pay[31 - 8 * i -: 8]);
            s = s - pay[31 - 8 * i -: 8];
        end
        exp_q.push_back(s);
        exp_q.push_back(8'h03);
        s = 8'h00 - len - c + fix;
    end
    put(8'h01);
    put(len);
    put(c);
    if (len == 8'h02)
        put(n);
    put(s);
    put(etx);
    limit = (c == `FQCS_CMD_BLANK) ? blank_check_timeout_per_block * n + 64 : 64;
    for (i = 0; i < limit && o_busy !== 1'b0; i = i + 1)
        @(negedge i_clk);
    // Host view of the reply: 0 normal, 1 abnormal, 2 time-out, 3 data frame error
    s = 8'h00;
    for (i = 6; i < u_host.got.size() - 1; i = i + 1)
        s = s + u_host.got[i];
    if (o_busy !== 1'b0 || u_host.got.size() < 5)
        outcome = 8'h02;
    else if (u_host.got[2] !== `FQCS_ST_ACK)
        outcome = 8'h01;
    else if (c == `FQCS_CMD_BLANK)
        outcome = 8'h00;
    else if (u_host.got.size() < 10)
        outcome = 8'h02;
    else if (s !== 8'h00 || u_host.got[u_host.got.size() - 1] !== `FQCS_ETX)
        outcome = 8'h03;
    else
        outcome = 8'h00;
    check(outcome, (st == `FQCS_ST_ACK) ? 8'h00 : 8'h01);
    check(8'(u_host.got.size()), 8'(exp_q.size()));
    foreach (exp_q[j])
        check(u_host.got[j], exp_q[j]);
    u_host.got.delete();
    repeat (4) @(posedge i_clk);
end
endtask
// ---------
// Scenarios
// ---------
task t_blank_ok;
begin
    slow <= 1'b1;
    run(`FQCS_CMD_BLANK, 8'h80, 8'h02, 8'h00, 8'h03, 8'h06);
    slow <= 1'b0;
end
endtask
task t_blank_dirty;
begin
    dirty <= 8'h02;
    run(`FQCS_CMD_BLANK, 8'h05, 8'h02, 8'h00, 8'h03, 8'h1B);
    dirty <= 8'hFF;
end
endtask
task t_blank_range;
begin
    run(`FQCS_CMD_BLANK, 8'h00, 8'h02, 8'h00, 8'h03, 8'h05);
    run(`FQCS_CMD_BLANK, 8'h81, 8'h02, 8'h00, 8'h03, 8'h05);
end
endtask
task t_bad_frames;
begin
    run(`FQCS_CMD_VER, 8'h00, 8'h01, 8'h01, 8'h03, 8'h07);
    run(`FQCS_CMD_SIG, 8'h00, 8'h01, 8'h00, 8'h04, 8'h15);
    run(`FQCS_CMD_BLANK, 8'h00, 8'h01, 8'h00, 8'h03, 8'h15);
    run(`FQCS_CMD_BLANK, 8'h00, 8'h00, 8'h00, 8'h03, 8'h15);
    run(8'h11, 8'h00, 8'h01, 8'h00, 8'h03, 8'h15);
end
endtask
task t_signature;
begin
    run(`FQCS_CMD_SIG, 8'h00, 8'h01, 8'h00, 8'h03, 8'h06);
    i_prot_fail <= 1'b1;
    run(`FQCS_CMD_SIG, 8'h00, 8'h01, 8'h00, 8'h03, 8'h20);
    i_prot_fail <= 1'b0;
end
endtask
task t_version;
begin
    slow <= 1'b1;
    run(`FQCS_CMD_VER, 8'h00, 8'h01, 8'h00, 8'h03, 8'h06);
    slow <= 1'b0;
end
endtask
initial
begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_blank_ok;
    t_blank_dirty;
    t_blank_range;
    t_bad_frames;
    t_signature;
    t_version;
    summarize;
end
endmodule
